/* src/dcf_pkg.sv */
// package: constants and types of the dual clock buffer with level flags
package dcf_pkg;
    localparam int              DCF_DATA_W      = 9;
    localparam int              DCF_DEPTH_DEF   = 256;
    localparam int              DCF_OFS_W       = 2 * DCF_DATA_W;
    localparam logic [17:0]     DCF_OFS_RESET   = 18'h00007;
    localparam logic            DCF_CFG_RESET   = 1'b1;

    // offset sequence, low then high half of each offset
    typedef enum logic [1:0] {
        DCF_OFS_AE_LO,
        DCF_OFS_AE_HI,
        DCF_OFS_AF_LO,
        DCF_OFS_AF_HI
    } dcf_ofs_state_t;
endpackage : dcf_pkg

/* src/dcf_mem.sv */
// simple dual port store with registered read data
`timescale 1ns/1ps
module dcf_mem
    import dcf_pkg::*;
#(
    parameter int DEPTH = DCF_DEPTH_DEF,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock
    input  wire logic                  i_core_clk,
    input  wire logic                  i_arst_n,
    // write side
    input  wire logic                  i_wr_en,
    input  wire logic [AW-1:0]         i_wr_addr,
    input  wire logic [DCF_DATA_W-1:0] i_wr_data,
    // read side
    input  wire logic                  i_rd_en,
    input  wire logic [AW-1:0]         i_rd_addr,
    output logic      [DCF_DATA_W-1:0] o_rd_data
);
    logic [DCF_DATA_W-1:0] store [DEPTH];

    always_ff @(posedge i_core_clk) begin
        if (i_wr_en) begin
            store[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            o_rd_data <= store[i_rd_addr];
        end
    end
endmodule : dcf_mem

/* src/dcf_top.sv */
// dual clock buffer with empty, full and programmable level flags
`timescale 1ns/1ps
module dcf_top
    import dcf_pkg::*;
#(
    parameter int DEPTH = DCF_DEPTH_DEF
) (
    // core clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_arst_n,
    // buffer control
    input  wire logic                  i_buffer_reset_n,
    // write port
    input  wire logic                  i_write_clk,
    input  wire logic                  i_push_enable_a_n,
    input  wire logic                  i_push_b_or_offset_load,
    input  wire logic [DCF_DATA_W-1:0] i_push_data,
    // read port
    input  wire logic                  i_read_clk,
    input  wire logic                  i_pop_enable_a_n,
    input  wire logic                  i_pop_enable_b_n,
    input  wire logic                  i_output_enable_n,
    output logic      [DCF_DATA_W-1:0] o_pop_data,
    output logic                       o_pop_data_oe_n,
    // flags
    output logic                       o_no_words_flag_n,
    output logic                       o_no_space_flag_n,
    output logic                       o_low_level_flag_n,
    output logic                       o_high_level_flag_n
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [DCF_OFS_W-1:0] DEPTH_W = DCF_OFS_W'(DEPTH);

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    ////////////////////////////////////////////////////////////////////////
    // clock pin edge detection
    logic           wclk_q;
    logic           rclk_q;
    logic           edge_armed;
    logic           cfg_two_wen;
    wire            w_rise = i_write_clk & ~wclk_q & edge_armed;
    wire            r_rise = i_read_clk & ~rclk_q & edge_armed;
    wire            in_reset = ~i_buffer_reset_n;

    // no pin edge until one real sample is held
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wclk_q     <= 1'b0;
            rclk_q     <= 1'b0;
            edge_armed <= 1'b0;
        end else begin
            wclk_q     <= i_write_clk;
            rclk_q     <= i_read_clk;
            edge_armed <= 1'b1;
        end
    end

    // mode strap caught while buffer reset is low
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_two_wen <= DCF_CFG_RESET;
        end else if (in_reset) begin
            cfg_two_wen <= i_push_b_or_offset_load;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request qualification
    wire load_active = ~cfg_two_wen & ~i_push_b_or_offset_load;
    wire wen_ok      = cfg_two_wen ? (~i_push_enable_a_n & i_push_b_or_offset_load)
                                   : (~i_push_enable_a_n & ~load_active);
    wire ofs_wr      = w_rise & load_active & ~i_push_enable_a_n & ~in_reset;
    wire rd_req      = r_rise & ~i_pop_enable_a_n & ~i_pop_enable_b_n & ~in_reset;
    wire ofs_rd      = rd_req & load_active;
    wire push        = w_rise & wen_ok & o_no_space_flag_n & ~in_reset;
    wire pop         = rd_req & ~load_active & o_no_words_flag_n;

    ////////////////////////////////////////////////////////////////////////
    // pointers and gray crossing
    logic [PW-1:0]  wptr;
    logic [PW-1:0]  rptr;
    logic [PW-1:0]  wgray;
    logic [PW-1:0]  rgray;
    logic [PW-1:0]  rgray_s1;
    logic [PW-1:0]  rgray_s2;
    logic [PW-1:0]  wgray_s1;
    logic [PW-1:0]  wgray_s2;
    wire  [PW-1:0]  next_wptr  = push ? wptr + PW'(1) : wptr;
    wire  [PW-1:0]  next_rptr  = pop ? rptr + PW'(1) : rptr;
    wire  [PW-1:0]  next_wgray = bin2gray(next_wptr);
    wire  [PW-1:0]  next_rgray = bin2gray(next_rptr);

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wptr  <= '0;
            rptr  <= '0;
            wgray <= '0;
            rgray <= '0;
        end else if (in_reset) begin
            wptr  <= '0;
            rptr  <= '0;
            wgray <= '0;
            rgray <= '0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            wgray <= next_wgray;
            rgray <= next_rgray;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rgray_s1 <= '0;
            rgray_s2 <= '0;
            wgray_s1 <= '0;
            wgray_s2 <= '0;
        end else begin
            rgray_s1 <= rgray;
            rgray_s2 <= rgray_s1;
            wgray_s1 <= wgray;
            wgray_s2 <= wgray_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // level computation
    logic [DCF_OFS_W-1:0] ae_ofs;
    logic [DCF_OFS_W-1:0] af_ofs;
    wire  [PW-1:0]        rbin_sync  = gray2bin(rgray_s2);
    wire  [PW-1:0]        wbin_sync  = gray2bin(wgray_s2);
    wire  [PW-1:0]        wr_level   = next_wptr - rbin_sync;
    wire  [PW-1:0]        rd_level   = wbin_sync - next_rptr;
    wire  [DCF_OFS_W-1:0] wr_free    = DEPTH_W - DCF_OFS_W'(wr_level);
    wire                  next_full  = (DCF_OFS_W'(wr_level) == DEPTH_W);
    wire                  next_af    = (wr_free <= af_ofs);
    wire                  next_empty = (rd_level == '0);
    wire                  next_ae    = (DCF_OFS_W'(rd_level) <= ae_ofs);

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_no_space_flag_n   <= 1'b1;
            o_high_level_flag_n <= 1'b1;
            o_no_words_flag_n   <= 1'b0;
            o_low_level_flag_n  <= 1'b0;
        end else if (in_reset) begin
            o_no_space_flag_n   <= 1'b1;
            o_high_level_flag_n <= 1'b1;
            o_no_words_flag_n   <= 1'b0;
            o_low_level_flag_n  <= 1'b0;
        end else begin
            o_no_space_flag_n   <= ~next_full;
            o_high_level_flag_n <= ~next_af;
            o_no_words_flag_n   <= ~next_empty;
            o_low_level_flag_n  <= ~next_ae;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // offset load and read-back sequencer
    dcf_ofs_state_t        ofs_state;
    dcf_ofs_state_t        next_ofs_state;
    logic [DCF_DATA_W-1:0] ofs_rd_data;
    logic                  out_sel_ofs;
    wire                   ofs_step = ofs_wr | ofs_rd;

    always_comb begin
        unique case (ofs_state)
            DCF_OFS_AE_LO: next_ofs_state = DCF_OFS_AE_HI;
            DCF_OFS_AE_HI: next_ofs_state = DCF_OFS_AF_LO;
            DCF_OFS_AF_LO: next_ofs_state = DCF_OFS_AF_HI;
            DCF_OFS_AF_HI: next_ofs_state = DCF_OFS_AE_LO;
        endcase
    end

    wire [DCF_DATA_W-1:0] ofs_sel_word =
        (ofs_state == DCF_OFS_AE_LO) ? ae_ofs[DCF_DATA_W-1:0] :
        (ofs_state == DCF_OFS_AE_HI) ? ae_ofs[DCF_OFS_W-1:DCF_DATA_W] :
        (ofs_state == DCF_OFS_AF_LO) ? af_ofs[DCF_DATA_W-1:0] :
                                       af_ofs[DCF_OFS_W-1:DCF_DATA_W];

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ofs_state <= DCF_OFS_AE_LO;
        end else if (in_reset) begin
            ofs_state <= DCF_OFS_AE_LO;
        end else if (ofs_step) begin
            ofs_state <= next_ofs_state;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ae_ofs <= DCF_OFS_RESET;
            af_ofs <= DCF_OFS_RESET;
        end else if (in_reset) begin
            ae_ofs <= DCF_OFS_RESET;
            af_ofs <= DCF_OFS_RESET;
        end else if (ofs_wr) begin
            unique case (ofs_state)
                DCF_OFS_AE_LO: ae_ofs[DCF_DATA_W-1:0]         <= i_push_data;
                DCF_OFS_AE_HI: ae_ofs[DCF_OFS_W-1:DCF_DATA_W] <= i_push_data;
                DCF_OFS_AF_LO: af_ofs[DCF_DATA_W-1:0]         <= i_push_data;
                DCF_OFS_AF_HI: af_ofs[DCF_OFS_W-1:DCF_DATA_W] <= i_push_data;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ofs_rd_data <= '0;
            out_sel_ofs <= 1'b0;
        end else if (ofs_rd) begin
            ofs_rd_data <= ofs_sel_word;
            out_sel_ofs <= 1'b1;
        end else if (pop) begin
            out_sel_ofs <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage and read port
    logic [DCF_DATA_W-1:0] mem_rd_data;

    dcf_mem #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_wr_en    (push),
        .i_wr_addr  (wptr[AW-1:0]),
        .i_wr_data  (i_push_data),
        .i_rd_en    (pop),
        .i_rd_addr  (rptr[AW-1:0]),
        .o_rd_data  (mem_rd_data)
    );

    assign o_pop_data      = out_sel_ofs ? ofs_rd_data : mem_rd_data;
    assign o_pop_data_oe_n = i_output_enable_n;
endmodule : dcf_top

/* bench/dcf_link_model.sv */
// partner: free running write and read clock pins of the far side
`timescale 1ns/1ps
module dcf_link_model (
    // core clock
    input  wire logic i_core_clk,
    // read clock tied to write clock when high
    input  wire logic i_tied,
    // pin clocks
    output logic      o_write_clk,
    output logic      o_read_clk
);
    logic       wclk = 1'b0;
    logic       rclk = 1'b0;
    logic       wcnt = 1'b0;
    logic [1:0] rcnt = 2'h0;
    assign o_write_clk = wclk;
    assign o_read_clk  = i_tied ? wclk : rclk;
    // never gated, different rates so phases drift
    always @(posedge i_core_clk) begin
        wcnt <= ~wcnt;
        rcnt <= (rcnt == 2'h2) ? 2'h0 : rcnt + 2'h1;
        if (wcnt) wclk <= ~wclk;
        if (rcnt == 2'h2) rclk <= ~rclk;
    end
endmodule : dcf_link_model

/* bench/dcf_top_asserts.sv */
// checker: flag, data and reset relations at the buffer ports
`timescale 1ns/1ps
module dcf_top_asserts
    import dcf_pkg::*;
#(
    parameter int DEPTH = DCF_DEPTH_DEF
) (
    input wire logic i_core_clk, i_arst_n, i_buffer_reset_n, i_write_clk, i_push_enable_a_n,
    input wire logic i_push_b_or_offset_load, i_read_clk, i_pop_enable_a_n, i_pop_enable_b_n,
    input wire logic [DCF_DATA_W-1:0] i_push_data, o_pop_data,
    input wire logic i_output_enable_n, o_pop_data_oe_n, o_no_words_flag_n, o_no_space_flag_n,
    input wire logic o_low_level_flag_n, o_high_level_flag_n
);
    logic wclk_q;
    wire  wr_take;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) wclk_q <= 1'b0;
        else wclk_q <= i_write_clk;
    end
    assign wr_take = i_write_clk & ~wclk_q & ~i_push_enable_a_n & i_push_b_or_offset_load
                     & o_no_space_flag_n & i_buffer_reset_n;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    sequence push_idle_s; i_push_enable_a_n [*6]; endsequence
    sequence pop_idle_s; i_pop_enable_a_n [*6]; endsequence
    reset_flags_a: assert property (!i_buffer_reset_n |=> o_no_space_flag_n && o_high_level_flag_n
        && !o_no_words_flag_n && !o_low_level_flag_n) else $error("flags not at reset values");
    oe_follow_a: assert property (o_pop_data_oe_n == i_output_enable_n)
        else $error("output enable not followed");
    data_holds_a: assert property (i_pop_enable_a_n && i_buffer_reset_n |=> $stable(o_pop_data))
        else $error("read data moved without a read");
    empty_refused_a: assert property (!o_no_words_flag_n && !i_pop_enable_a_n && !i_pop_enable_b_n
        && i_push_b_or_offset_load && i_buffer_reset_n |=> $stable(o_pop_data)) else $error("read while empty");
    empty_holds_a: assert property (push_idle_s ##0 !o_no_words_flag_n |=> !o_no_words_flag_n)
        else $error("data reported without a write");
    full_holds_a: assert property (pop_idle_s ##0 !o_no_space_flag_n && i_buffer_reset_n
        |=> !o_no_space_flag_n) else $error("space reported without a read");
    fill_through_a: assert property (wr_take && !o_no_words_flag_n |-> ##[1:4] o_no_words_flag_n)
        else $error("written word not readable in time");
    full_high_a: assert property (!o_no_space_flag_n |-> !o_high_level_flag_n)
        else $error("full without almost full");
    empty_low_a: assert property (!o_no_words_flag_n |-> !o_low_level_flag_n)
        else $error("empty without almost empty");
endmodule : dcf_top_asserts
bind dcf_top dcf_top_asserts #(.DEPTH(DEPTH)) u_asserts (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_buffer_reset_n(i_buffer_reset_n), .i_write_clk(i_write_clk), .i_push_enable_a_n(i_push_enable_a_n),
    .i_push_b_or_offset_load(i_push_b_or_offset_load), .i_read_clk(i_read_clk), .i_push_data(i_push_data),
    .i_pop_enable_a_n(i_pop_enable_a_n), .i_pop_enable_b_n(i_pop_enable_b_n), .o_pop_data(o_pop_data),
    .i_output_enable_n(i_output_enable_n), .o_pop_data_oe_n(o_pop_data_oe_n),
    .o_no_words_flag_n(o_no_words_flag_n), .o_no_space_flag_n(o_no_space_flag_n),
    .o_low_level_flag_n(o_low_level_flag_n), .o_high_level_flag_n(o_high_level_flag_n));

/* bench/dcf_top_tb.sv */
// testbench: dual clock buffer modes, order, flags and offsets
`timescale 1ns/1ps
module dcf_top_tb;
    import dcf_pkg::*;
    localparam int DEPTH = 256;
    logic                  core_clk = 1'b0, arst_n = 1'b0, buf_rst_n = 1'b0, wen_a_n = 1'b1, pin = 1'b1;
    logic                  ren_a_n = 1'b1, ren_b_n = 1'b1, oe_n = 1'b0, tied = 1'b0;
    logic [DCF_DATA_W-1:0] wdata = 9'h000;
    logic [DCF_DATA_W-1:0] rdata;
    logic                  wr_clk, rd_clk, rdata_oe_n, empty_n, full_n, low_n, high_n;
    wire  [DCF_DATA_W-1:0] pop_bus = rdata_oe_n ? 9'bZ : rdata;
    int                    errors = 0;
    int                    samples_checked = 0;
    always #2.5 core_clk = ~core_clk;
    dcf_link_model partner (.i_core_clk(core_clk), .i_tied(tied), .o_write_clk(wr_clk), .o_read_clk(rd_clk));
    dcf_top #(.DEPTH(DEPTH)) dut (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_buffer_reset_n(buf_rst_n),
        .i_write_clk(wr_clk), .i_push_enable_a_n(wen_a_n), .i_push_b_or_offset_load(pin), .i_push_data(wdata),
        .i_read_clk(rd_clk), .i_pop_enable_a_n(ren_a_n), .i_pop_enable_b_n(ren_b_n),
        .i_output_enable_n(oe_n), .o_pop_data(rdata), .o_pop_data_oe_n(rdata_oe_n),
        .o_no_words_flag_n(empty_n), .o_no_space_flag_n(full_n), .o_low_level_flag_n(low_n),
        .o_high_level_flag_n(high_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [8:0] seen, input logic [8:0] expected);
        samples_checked++;
        if (seen !== expected) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check
    task automatic report_and_stop();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic settle();
        repeat (6) @(negedge core_clk);
    endtask : settle
    task automatic push(input logic [8:0] d);
        do @(negedge core_clk); while (wr_clk !== 1'b0);
        @(posedge core_clk);
        wen_a_n <= 1'b0;
        wdata   <= d;
        do @(negedge core_clk); while (wr_clk !== 1'b1);
        @(posedge core_clk);
        wen_a_n <= 1'b1;
    endtask : push
    task automatic pop(input logic b_n, input logic [8:0] exp);
        do @(negedge core_clk); while (rd_clk !== 1'b0);
        @(posedge core_clk);
        ren_a_n <= 1'b0;
        ren_b_n <= b_n;
        do @(negedge core_clk); while (rd_clk !== 1'b1);
        @(posedge core_clk);
        ren_a_n <= 1'b1;
        ren_b_n <= 1'b1;
        @(negedge core_clk);
        check(rdata, exp);
    endtask : pop
    task automatic breset(input logic strap);
        @(posedge core_clk);
        buf_rst_n <= 1'b0;
        pin       <= strap;
        repeat (3) @(posedge core_clk);
        buf_rst_n <= 1'b1;
        @(posedge core_clk);
        pin       <= 1'b1;
        @(negedge core_clk);
    endtask : breset
    ////////////////////////////////////////////////////////////////////////
    task automatic test_two_enable();
        breset(1'b1);
        check({5'h00, full_n, high_n, empty_n, low_n}, 9'h00C);
        @(posedge core_clk) pin <= 1'b0;
        push(9'h1A5);
        settle();
        check(empty_n, 1'b0);
        @(posedge core_clk) pin <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            push(9'(9'h100 + i));
            settle();
            check(low_n, 1'(i == 7));
        end
        pop(1'b0, 9'h100);
        pop(1'b1, 9'h100);
        for (int i = 1; i < 8; i++) pop(1'b0, 9'(9'h100 + i));
        settle();
        check(empty_n, 1'b0);
        pop(1'b0, 9'h107);
    endtask : test_two_enable
    task automatic test_full();
        for (int i = 0; i < DEPTH; i++) begin
            push(9'(i));
            if (i == 247 || i == 248 || i == DEPTH - 1) begin
                settle();
                check(high_n, 1'(i == 247));
                check(full_n, 1'(i != DEPTH - 1));
            end
        end
        push(9'h1FF);
        for (int i = 0; i < DEPTH; i++) pop(1'b0, 9'(i));
        settle();
        check(empty_n, 1'b0);
    endtask : test_full
    task automatic test_oe();
        @(posedge core_clk) oe_n <= 1'b1;
        @(negedge core_clk);
        check(pop_bus, 9'bZ);
        @(posedge core_clk) oe_n <= 1'b0;
        @(negedge core_clk);
        check(pop_bus, 9'h0FF);
    endtask : test_oe
    task automatic test_tied();
        @(posedge core_clk) tied <= 1'b1;
        settle();
        push(9'h0A1);
        push(9'h0A2);
        settle();
        check(empty_n, 1'b1);
        pop(1'b0, 9'h0A1);
        pop(1'b0, 9'h0A2);
        settle();
        check(empty_n, 1'b0);
        @(posedge core_clk) tied <= 1'b0;
        settle();
    endtask : test_tied
    task automatic test_offsets();
        breset(1'b0);
        @(posedge core_clk) pin <= 1'b0;
        push(9'h002);
        push(9'h000);
        push(9'h003);
        push(9'h000);
        pop(1'b0, 9'h002);
        pop(1'b0, 9'h000);
        pop(1'b0, 9'h003);
        pop(1'b0, 9'h000);
        @(posedge core_clk) pin <= 1'b1;
        push(9'h011);
        push(9'h022);
        settle();
        check(low_n, 1'b0);
        push(9'h033);
        settle();
        check(low_n, 1'b1);
        pop(1'b0, 9'h011);
    endtask : test_offsets
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        test_two_enable();
        test_full();
        test_oe();
        test_tied();
        test_offsets();
        report_and_stop();
    end
endmodule : dcf_top_tb
